//--- core/binary_conditioner.sv
// One signal conditioner or non-volatile element.
// Assumes trig, clear and mode come from logic on pclk.
`timescale 1ns/100ps

module binary_conditioner
	import logic_blocks_pkg::*;
(
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Element inputs.
	input  wire logic       trig,
	input  wire logic       clear,
	input  wire logic [1:0] mode,
	// Restore from persistent storage.
	input  wire logic       restore_en,
	input  wire logic       restore_val,
	// Element output.
	output logic            q
);

	typedef struct packed {
		logic trig_q;
		logic q;
	} cond_state_s;

	cond_state_s s;
	cond_state_s next_s;

	always_comb begin
		next_s        = s;
		next_s.trig_q = trig;
		if (clear) begin
			next_s.q = 1'b0;
		end else if (restore_en) begin
			next_s.q = restore_val;
		end else begin
			unique case (cond_mode_e'(mode))
				COND_PASS: begin
					next_s.q = trig;
				end
				COND_INVERT: begin
					next_s.q = ~trig & ~clear;
				end
				COND_RISE_HOLD: begin
					if (trig & ~s.trig_q) begin
						next_s.q = 1'b1;
					end
				end
				COND_FALL_HOLD: begin
					if (~trig & s.trig_q) begin
						next_s.q = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

endmodule

//--- core/timer_signal_logic.sv
// Timers, signal conditioners, non-volatile elements and flashers with an APB slave.
// Assumes all element inputs come from logic on pclk; nv_saved is held stable
// by the persistent store from reset release onward.
`timescale 1ns/100ps

// Summary of operation
// - A timer output stays 0 while its reset input is active.
// - An active timer reset clears its elapsed time to zero.
// - Timer modes: on-delay, on-delay held, off-delay, fixed pulse.
// - Timer duration counts 100 ms steps from 0 to 6553.5 s, default 0.
// - Each timer elapsed time is a readable word output and register.
// - Trigger and reset are levels; pulse mode starts on a rising edge.
// - Timer count is a parameter of up to six.
// - Conditioner modes: pass, invert, rising-edge hold, falling-edge hold.
// - Conditioner reset clears output and held state; output stays 0.
// - Inverting conditioner acts as NOR of trigger and reset.
// - Non-volatile elements act as conditioners, state restored after supply loss.
// - Up to four non-volatile elements.
// - Up to six conditioners, each with trigger, reset, mode, output.
// - A flasher toggles at 1 Hz while its input is high, else 0.
// - Three independent flashers.
module timer_signal_logic
	import logic_blocks_pkg::*;
#(
	parameter int NUM_TIMERS  = MAX_TIMERS,
	parameter int NUM_COND    = MAX_COND,
	parameter int NUM_NV      = MAX_NV,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// APB slave.
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [ADDR_W-1:0]                 paddr,
	input  wire logic [31:0]                       pwdata,
	output logic [31:0]                            prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Timers.
	input  wire logic [NUM_TIMERS-1:0]             timer_trig,
	input  wire logic [NUM_TIMERS-1:0]             timer_clear,
	output logic      [NUM_TIMERS-1:0]             timer_out,
	output logic      [NUM_TIMERS-1:0][DUR_W-1:0]  timer_elapsed,
	// Signal conditioners.
	input  wire logic [NUM_COND-1:0]               cond_trig,
	input  wire logic [NUM_COND-1:0]               cond_clear,
	output logic      [NUM_COND-1:0]               cond_out,
	// Non-volatile elements.
	input  wire logic [NUM_NV-1:0]                 nv_trig,
	input  wire logic [NUM_NV-1:0]                 nv_clear,
	input  wire logic [NUM_NV-1:0]                 nv_saved,
	output logic      [NUM_NV-1:0]                 nv_out,
	// Flashers.
	input  wire logic [NUM_FLASH-1:0]              flash_in,
	output logic      [NUM_FLASH-1:0]              flash_out
);

	typedef struct packed {
		logic [31:0]                            prdata;
		logic                                   pready;
		logic                                   pslverr;
		logic [TICK_CNT_W-1:0]                  tick_cnt;
		logic                                   tick;
		logic [NUM_TIMERS-1:0][DUR_W-1:0]       dur;
		logic [NUM_TIMERS-1:0][MODE_W-1:0]      tmode;
		logic [NUM_TIMERS-1:0][DUR_W-1:0]       elapsed;
		logic [NUM_TIMERS-1:0]                  run;
		logic [NUM_TIMERS-1:0]                  tout;
		logic [NUM_TIMERS-1:0]                  trig_q;
		logic [NUM_COND-1:0][MODE_W-1:0]        cmode;
		logic [NUM_NV-1:0][MODE_W-1:0]          nmode;
		logic [NUM_FLASH-1:0][FLASH_CNT_W-1:0]  fcnt;
		logic [NUM_FLASH-1:0]                   fout;
		logic                                   restore;
	} core_state_s;

	core_state_s                      s;
	core_state_s                      next_s;
	logic                             access;
	logic                             hit;
	logic                             wr_commit;
	logic [31:0]                      rdata;
	logic [NUM_COND-1:0]              cond_q;
	logic [NUM_NV-1:0]                nv_q;

	always_comb begin
		next_s    = s;
		access    = psel & penable;
		hit       = 1'b0;
		rdata     = 32'h0000_0000;
		wr_commit = 1'b0;

		// Address decode and read data.
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (paddr == ADDR_W'(TIMER_CFG_BASE + REG_STRIDE * i)) begin
				hit = 1'b1;
				rdata[TCFG_DUR_LSB +: DUR_W]   = s.dur[i];
				rdata[TCFG_MODE_LSB +: MODE_W] = s.tmode[i];
			end
			if (paddr == ADDR_W'(TIMER_VAL_BASE + REG_STRIDE * i)) begin
				hit = 1'b1;
				rdata[DUR_W-1:0] = s.elapsed[i];
			end
		end
		if (paddr == COND_TYPE_OFS) begin
			hit = 1'b1;
			rdata[NUM_COND*MODE_W-1:0] = s.cmode;
		end
		if (paddr == NV_TYPE_OFS) begin
			hit = 1'b1;
			rdata[NUM_NV*MODE_W-1:0] = s.nmode;
		end
		if (paddr == STATUS_OFS) begin
			hit = 1'b1;
			rdata[ST_TIMER_LSB +: NUM_TIMERS] = s.tout;
			rdata[ST_COND_LSB +: NUM_COND]    = cond_q;
			rdata[ST_NV_LSB +: NUM_NV]        = nv_q;
			rdata[ST_FLASH_LSB +: NUM_FLASH]  = s.fout;
		end

		// One wait state, then the answer; unmapped addresses answer with an error.
		next_s.pready  = access & ~s.pready;
		next_s.pslverr = access & ~s.pready & ~hit;
		if (access & ~s.pready) begin
			next_s.prdata = (hit & ~pwrite) ? rdata : 32'h0000_0000;
		end
		wr_commit = access & s.pready & pwrite & hit;

		// Register writes take effect at the completing edge.
		if (wr_commit) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				if (paddr == ADDR_W'(TIMER_CFG_BASE + REG_STRIDE * i)) begin
					next_s.dur[i]   = pwdata[TCFG_DUR_LSB +: DUR_W];
					next_s.tmode[i] = pwdata[TCFG_MODE_LSB +: MODE_W];
				end
			end
			if (paddr == COND_TYPE_OFS) begin
				next_s.cmode = pwdata[NUM_COND*MODE_W-1:0];
			end
			if (paddr == NV_TYPE_OFS) begin
				next_s.nmode = pwdata[NUM_NV*MODE_W-1:0];
			end
		end

		// Device tick of 100 ms.
		if (s.tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
			next_s.tick_cnt = '0;
			next_s.tick     = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 1'b1;
			next_s.tick     = 1'b0;
		end

		// Timers.
		for (int i = 0; i < NUM_TIMERS; i++) begin
			next_s.trig_q[i] = timer_trig[i];
			if (timer_clear[i]) begin
				next_s.elapsed[i] = '0;
				next_s.run[i]     = 1'b0;
				next_s.tout[i]    = 1'b0;
			end else begin
				unique case (timer_mode_e'(s.tmode[i]))
					TMR_ON_DELAY: begin
						if (timer_trig[i]) begin
							if (s.tick && s.elapsed[i] < s.dur[i]) begin
								next_s.elapsed[i] = s.elapsed[i] + 1'b1;
							end
							next_s.tout[i] = (s.elapsed[i] >= s.dur[i]);
						end else begin
							next_s.elapsed[i] = '0;
							next_s.tout[i]    = 1'b0;
						end
					end
					TMR_ON_DELAY_HOLD: begin
						if (timer_trig[i]) begin
							next_s.run[i] = 1'b1;
						end
						if (timer_trig[i] | s.run[i]) begin
							if (s.tick && s.elapsed[i] < s.dur[i]) begin
								next_s.elapsed[i] = s.elapsed[i] + 1'b1;
							end
							if (s.elapsed[i] >= s.dur[i]) begin
								next_s.tout[i] = 1'b1;
							end
						end
					end
					TMR_OFF_DELAY: begin
						if (timer_trig[i]) begin
							next_s.elapsed[i] = '0;
							next_s.run[i]     = 1'b1;
							next_s.tout[i]    = 1'b1;
						end else if (s.run[i]) begin
							if (s.elapsed[i] >= s.dur[i]) begin
								next_s.run[i]  = 1'b0;
								next_s.tout[i] = 1'b0;
							end else if (s.tick) begin
								next_s.elapsed[i] = s.elapsed[i] + 1'b1;
							end
						end
					end
					TMR_PULSE: begin
						if (timer_trig[i] & ~s.trig_q[i]) begin
							next_s.elapsed[i] = '0;
							next_s.run[i]     = 1'b1;
							next_s.tout[i]    = 1'b1;
						end else if (s.run[i]) begin
							if (s.elapsed[i] >= s.dur[i]) begin
								next_s.run[i]  = 1'b0;
								next_s.tout[i] = 1'b0;
							end else if (s.tick) begin
								next_s.elapsed[i] = s.elapsed[i] + 1'b1;
							end
						end
					end
				endcase
			end
		end

		// Flashers: half period of 500 ms gives 1 Hz.
		for (int i = 0; i < NUM_FLASH; i++) begin
			if (!flash_in[i]) begin
				next_s.fcnt[i] = '0;
				next_s.fout[i] = 1'b0;
			end else if (s.tick) begin
				if (s.fcnt[i] == FLASH_CNT_W'(FLASH_HALF_TICKS - 1)) begin
					next_s.fcnt[i] = '0;
					next_s.fout[i] = ~s.fout[i];
				end else begin
					next_s.fcnt[i] = s.fcnt[i] + 1'b1;
				end
			end
		end

		// Restore from persistent storage only in the first cycle after reset.
		next_s.restore = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.dur      <= {NUM_TIMERS{DUR_DEFAULT}};
			s.tmode    <= {NUM_TIMERS{TMR_MODE_DEFAULT}};
			s.cmode    <= {NUM_COND{COND_MODE_DEFAULT}};
			s.nmode    <= {NUM_NV{COND_MODE_DEFAULT}};
			s.restore  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Signal conditioners.
	for (genvar g = 0; g < NUM_COND; g++) begin : g_cond
		binary_conditioner u_cond (
			.pclk        (pclk),
			.presetn     (presetn),
			.trig        (cond_trig[g]),
			.clear       (cond_clear[g]),
			.mode        (s.cmode[g]),
			.restore_en  (1'b0),
			.restore_val (1'b0),
			.q           (cond_q[g])
		);
	end

	// Non-volatile elements; nv_out feeds the persistent store.
	for (genvar g = 0; g < NUM_NV; g++) begin : g_nv
		binary_conditioner u_nv (
			.pclk        (pclk),
			.presetn     (presetn),
			.trig        (nv_trig[g]),
			.clear       (nv_clear[g]),
			.mode        (s.nmode[g]),
			.restore_en  (s.restore),
			.restore_val (nv_saved[g]),
			.q           (nv_q[g])
		);
	end

	assign prdata        = s.prdata;
	assign pready        = s.pready;
	assign pslverr       = s.pslverr;
	assign timer_out     = s.tout;
	assign timer_elapsed = s.elapsed;
	assign cond_out      = cond_q;
	assign nv_out        = nv_q;
	assign flash_out     = s.fout;

endmodule

//--- dv/testbench.sv
// Self-checking bench of the timer and logic block set.
// Assumes a tick of ten cycles so timer, hold and flash waits stay short.
`timescale 1ns/100ps

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("Error at %0t: got %h exp %h", $time, (a), (b)); end end

module testbench;
	localparam int TK = 10;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0, prdata, rd;
	logic             pready, pslverr, err, b;
	logic [5:0]       timer_trig = 6'h00, timer_clear = 6'h00, timer_out, t = 6'h00, c = 6'h00;
	logic [5:0]       cond_trig = 6'h00, cond_clear = 6'h00, cond_out, p = 6'h00, h = 6'h00, e;
	logic [5:0][15:0] timer_elapsed;
	logic [3:0]       nv_trig = 4'h0, nv_clear = 4'h0, nv_saved = 4'ha, nv_out;
	logic [2:0]       flash_in = 3'h0, flash_out;
	logic [15:0]      seed = 16'hbfef;
	int               bad_count = 0, checks = 0, cyc = 0, n;
	int               first [4], last [4];
	int               fl [4] = '{10, 10, 1, 1}, fh [4] = '{24, 24, 3, 3};
	int               ll [4] = '{40, 80, 50, 10}, lh [4] = '{42, 80, 64, 24};

	timer_signal_logic #(.TICK_CYCLES(TK)) i_timer_signal_logic (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_trig(timer_trig), .timer_clear(timer_clear), .timer_out(timer_out),
		.timer_elapsed(timer_elapsed), .cond_trig(cond_trig), .cond_clear(cond_clear),
		.cond_out(cond_out), .nv_trig(nv_trig), .nv_clear(nv_clear), .nv_saved(nv_saved),
		.nv_out(nv_out), .flash_in(flash_in), .flash_out(flash_out)
	);

	always #2.5 pclk = ~pclk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic results();
		$display("Checks %0d, errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// One bus transfer; waits for ready however long it takes.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1 `CHK(nv_out, 4'ha)
		for (int m = 0; m < 4; m++) apb(1'b1, 12'(4 * m), {14'h0, 2'(m), 16'h0002});
		apb(1'b0, 12'h00c, 32'h0);
		`CHK(rd, 32'h0003_0002)
		apb(1'b0, 12'h010, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 12'h100, 32'h0);
		`CHK(err, 1'b1)
		// Timers 0 to 3 run one mode each; timer 4 is held in clear.
		@(posedge pclk);
		timer_trig <= 6'h1f;
		timer_clear <= 6'h10;
		for (int i = 1; i <= 80; i++) begin
			@(posedge pclk);
			if (i == 40) timer_trig <= 6'h00;
			#1;
			for (int k = 0; k < 4; k++) if (timer_out[k] === 1'b1) begin
				if (first[k] == 0) first[k] = i;
				last[k] = i;
			end
			if (i == first[0]) `CHK(timer_elapsed[0], 16'h0002)
			`CHK(timer_out[4], 1'b0)
		end
		for (int k = 0; k < 4; k++) begin
			`CHK(first[k] >= fl[k] && first[k] <= fh[k], 1'b1)
			`CHK(last[k] >= ll[k] && last[k] <= lh[k], 1'b1)
		end
		@(posedge pclk);
		timer_trig <= 6'h01;
		timer_clear <= 6'h3f;
		repeat (3) @(posedge pclk);
		#1 `CHK(timer_out, 6'h00)
		`CHK(timer_elapsed[1], 16'h0000)
		@(posedge pclk);
		timer_clear <= 6'h00;
		n = 0;
		while (timer_out[0] !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		`CHK(n >= 10 && n < 40, 1'b1)
		apb(1'b0, 12'h020, 32'h0);
		`CHK(rd, 32'h2)
		// Conditioners and stored elements against a bitwise model.
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h040, {16'h0, {8{2'(m)}}});
			apb(1'b1, 12'h044, {24'h0, {4{2'(m)}}});
			for (int i = 0; i < 40; i++) begin
				@(posedge pclk);
				case (m)
					0: e = t & ~c;
					1: e = ~(t | c);
					2: h = (h | (t & ~p)) & ~c;
					default: h = (h | (~t & p)) & ~c;
				endcase
				if (m > 1) e = h;
				p = t;
				seed = lfsr(seed);
				t = seed[5:0];
				c = (i == 0) ? 6'h3f : seed[11:6] & seed[15:10];
				cond_trig <= t;
				cond_clear <= c;
				nv_trig <= t[3:0];
				nv_clear <= c[3:0];
				#1;
				if (i > 0) `CHK(cond_out, e)
				if (i > 0) `CHK(nv_out, e[3:0])
			end
		end
		apb(1'b0, 12'h040, 32'h0);
		`CHK(rd, 32'h0000_0fff)
		apb(1'b0, 12'h044, 32'h0);
		`CHK(rd, 32'h0000_00ff)
		@(posedge pclk);
		flash_in <= 3'h5;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			b = flash_out[0];
			while (flash_out[0] === b && n < 90) begin
				@(posedge pclk);
				n++;
			end
		end
		`CHK(n, 50)
		`CHK(flash_out[1], 1'b0)
		results();
	end
endmodule

//--- dv/timer_signal_logic_sva.sv
// Checker of the timer and logic block set, watching its top ports.
// Assumes the bind below attaches it to each instance of the top module.
`timescale 1ns/100ps

module timer_signal_logic_sva
	import logic_blocks_pkg::*;
#(
	parameter int NUM_TIMERS  = MAX_TIMERS,
	parameter int NUM_COND    = MAX_COND,
	parameter int NUM_NV      = MAX_NV,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock, reset and bus handshake.
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pready,
	input wire logic                             pslverr,
	// Element pins.
	input wire logic [NUM_TIMERS-1:0]            timer_clear,
	input wire logic [NUM_TIMERS-1:0]            timer_out,
	input wire logic [NUM_TIMERS-1:0][DUR_W-1:0] timer_elapsed,
	input wire logic [NUM_COND-1:0]              cond_clear,
	input wire logic [NUM_COND-1:0]              cond_out,
	input wire logic [NUM_NV-1:0]                nv_clear,
	input wire logic [NUM_NV-1:0]                nv_out,
	input wire logic [NUM_FLASH-1:0]             flash_in,
	input wire logic [NUM_FLASH-1:0]             flash_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	timer_clear_a: assert property (1'b1 |=> (timer_out & $past(timer_clear)) == '0)
		else $error("Timer output high after a clear cycle.");
	elapsed_clear_a: assert property (timer_clear[0] |=> timer_elapsed[0] == 16'h0000)
		else $error("Elapsed time not zero after a clear.");
	elapsed_step_a: assert property ($changed(timer_elapsed[0]) |->
		timer_elapsed[0] == $past(timer_elapsed[0]) + 16'h0001 || timer_elapsed[0] == 16'h0000)
		else $error("Elapsed time jumped.");
	cond_clear_a: assert property (1'b1 |=> (cond_out & $past(cond_clear)) == '0)
		else $error("Conditioner output high after a clear cycle.");
	nv_clear_a: assert property (1'b1 |=> (nv_out & $past(nv_clear)) == '0)
		else $error("Stored element output high after a clear cycle.");
	flash_off_a: assert property (1'b1 |=> (flash_out & ~$past(flash_in)) == '0)
		else $error("Flasher output high with its input low.");
	bus_answer_a: assert property (psel && $rose(penable) |=> pready)
		else $error("Bus answer not in the second access cycle.");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held longer than one cycle.");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("Error flag without ready.");
endmodule

bind timer_signal_logic timer_signal_logic_sva #(
	.NUM_TIMERS(NUM_TIMERS), .NUM_COND(NUM_COND), .NUM_NV(NUM_NV), .TICK_CYCLES(TICK_CYCLES)
) i_timer_signal_logic_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .timer_clear(timer_clear), .timer_out(timer_out),
	.timer_elapsed(timer_elapsed), .cond_clear(cond_clear), .cond_out(cond_out),
	.nv_clear(nv_clear), .nv_out(nv_out), .flash_in(flash_in), .flash_out(flash_out)
);

//--- shared/logic_blocks_pkg.sv
// Constants, modes and register map of the binary logic block set.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
package logic_blocks_pkg;

	// Instance limits.
	localparam int MAX_TIMERS = 6;
	localparam int MAX_COND   = 6;
	localparam int MAX_NV     = 4;
	localparam int NUM_FLASH  = 3;

	// Clock and timing.
	localparam int CLK_HZ           = 200_000_000;
	localparam int TICK_MS          = 100;
	localparam int TICK_CYCLES_DEF  = TICK_MS * (CLK_HZ / 1000);
	localparam int TICK_CNT_W       = 25;
	localparam int FLASH_HALF_MS    = 500;
	localparam int FLASH_HALF_TICKS = FLASH_HALF_MS / TICK_MS;
	localparam int FLASH_CNT_W      = 3;

	// Timer duration word, in 100 ms steps.
	localparam int             DUR_W       = 16;
	localparam logic [15:0]    DUR_DEFAULT = 16'h0000;

	// Register map.
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] TIMER_CFG_BASE = 12'h000;
	localparam logic [11:0] TIMER_VAL_BASE = 12'h020;
	localparam logic [11:0] COND_TYPE_OFS  = 12'h040;
	localparam logic [11:0] NV_TYPE_OFS    = 12'h044;
	localparam logic [11:0] STATUS_OFS     = 12'h048;
	localparam logic [11:0] REG_STRIDE     = 12'h004;

	// Field positions.
	localparam int TCFG_DUR_LSB  = 0;
	localparam int TCFG_MODE_LSB = 16;
	localparam int MODE_W        = 2;
	localparam int ST_TIMER_LSB  = 0;
	localparam int ST_COND_LSB   = 8;
	localparam int ST_NV_LSB     = 16;
	localparam int ST_FLASH_LSB  = 24;

	typedef enum logic [1:0] {
		TMR_ON_DELAY,
		TMR_ON_DELAY_HOLD,
		TMR_OFF_DELAY,
		TMR_PULSE
	} timer_mode_e;

	typedef enum logic [1:0] {
		COND_PASS,
		COND_INVERT,
		COND_RISE_HOLD,
		COND_FALL_HOLD
	} cond_mode_e;

	localparam logic [1:0] TMR_MODE_DEFAULT  = 2'h0;
	localparam logic [1:0] COND_MODE_DEFAULT = 2'h0;

endpackage
